// *** tuning_pkg.sv ***
// tuning_pkg: offsets, field layout, reset values and carrier types for the
// phy transmit/receive tuning register bank.
// assumes a dword-wide configuration access port with byte enables.
package tuning_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // configuration offsets (byte addresses of aligned dwords)
   localparam logic [7:0]  tx_tuning_offset   = 8'he4;
   localparam logic [7:0]  rx_eq_offset       = 8'he8;
   localparam logic [7:0]  override_offset    = 8'hec;

   // reset values
   localparam logic [31:0] tx_tuning_reset    = 32'h0000_0000;
   localparam logic [31:0] rx_eq_reset        = 32'h0000_0000;
   localparam logic [31:0] override_reset     = 32'h0000_0000;

   // writable bits of the override enable register
   localparam logic [31:0] override_mask      = 32'h0000_7777;

   ////////////////////////////////////////////////////////////////////////////
   // field layout: each port owns one byte of each tuning word
   localparam int          num_ports          = 4;
   localparam int          field_w            = 4;
   localparam int          port_stride        = 8;
   localparam int          high_nibble_lo     = 4;
   localparam int          low_nibble_lo      = 0;

   // override enable layout: one nibble per port
   localparam int          ovr_stride         = 4;
   localparam int          ovr_deemph_bit     = 0;
   localparam int          ovr_swing_bit      = 1;
   localparam int          ovr_eq_bit         = 2;

   // ports present on the two-port variant
   localparam int          two_port_count     = 2;

   // built-in phy defaults used while an override is clear
   localparam logic [3:0]  default_swing      = 4'h0;
   localparam logic [3:0]  default_deemph     = 4'h0;
   localparam logic [3:0]  default_eq_init    = 4'h0;
   localparam logic [3:0]  default_eq_func    = 4'h0;

   // reset pins are active low, so their idle level is all ones
   localparam int          reset_pin_count    = 3;
   localparam logic [2:0]  reset_pin_idle     = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_s;

   typedef struct packed {
      logic [3:0] swing;
      logic [3:0] deemph;
      logic [3:0] eq_init;
      logic [3:0] eq_func;
   } tuning_s;

   typedef struct packed {
      logic [3:0] swing;
      logic [3:0] deemph;
      logic [3:0] eq_init;
      logic [3:0] eq_func;
      logic       swing_ov;
      logic       deemph_ov;
      logic       eq_ov;
   } phy_port_s;

endpackage

// *** pin_sync.sv ***
// pin_sync: three-stage synchroniser for asynchronous pins with a filter
// that accepts a change only once the second and third stages agree.
// assumes srst is synchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   ////////////////////////////////////////////////////////////////////////////
   // per bit: take the value when stages two and three agree, else hold
   always_comb begin
      next_level = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & level);
   end

   // stage registers; s1 feeds only s2
   always_ff @(posedge clk) begin
      if (srst) begin
         s1    <= INIT;
         s2    <= INIT;
         s3    <= INIT;
         level <= INIT;
      end else begin
         s1    <= pin;
         s2    <= s1;
         s3    <= s2;
         level <= next_level;
      end
   end

endmodule

// *** port_override.sv ***
// port_override: registered per-port selection between the software tuning
// fields and the phy's built-in defaults.
// assumes rst is synchronous to clk and combines every reset source.
`timescale 1ns/1ps
module port_override
   import tuning_pkg::*;
#(
   parameter bit PRESENT = 1'b1
) (
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire tuning_s   field,
   input  wire logic      swing_ov,
   input  wire logic      deemph_ov,
   input  wire logic      eq_ov,
   output phy_port_s      q
);

   phy_port_s next_q;
   logic      use_swing;
   logic      use_deemph;
   logic      use_eq;

   ////////////////////////////////////////////////////////////////////////////
   // an absent port never leaves its defaults
   always_comb begin
      use_swing         = PRESENT && swing_ov;
      use_deemph        = PRESENT && deemph_ov;
      use_eq            = PRESENT && eq_ov;
      next_q.swing      = use_swing  ? field.swing   : default_swing;
      next_q.deemph     = use_deemph ? field.deemph  : default_deemph;
      next_q.eq_init    = use_eq     ? field.eq_init : default_eq_init;
      next_q.eq_func    = use_eq     ? field.eq_func : default_eq_func;
      next_q.swing_ov   = use_swing;
      next_q.deemph_ov  = use_deemph;
      next_q.eq_ov      = use_eq;
   end

   // output register
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '{swing: default_swing, deemph: default_deemph,
                eq_init: default_eq_init, eq_func: default_eq_func,
                swing_ov: 1'b0, deemph_ov: 1'b0, eq_ov: 1'b0};
      end else begin
         q <= next_q;
      end
   end

endmodule

// *** phy_tx_rx_tuning_override_regs.sv ***
// phy_tx_rx_tuning_override_regs: configuration registers holding transmit
// swing / de-emphasis and receiver equalizer codes for four phy ports, plus
// the per-port override enables, with registered outputs to the phy.
// assumes configuration requests are one-cycle strobes on clk and that the
// three reset pins are asynchronous, active low.
//
// Notes on behaviour
// - transmit tuning register, 32-bit read/write at E4h, resets to zero.
// - receiver equalizer register, 32-bit read/write at E8h, resets to zero.
// - pcie, global or power-on reset clears both tuning registers.
// - bits 31:28 of transmit word drive port 4 swing when overridden.
// - bits 27:24 of transmit word drive port 4 de-emphasis when overridden.
// - bits 23:20 of transmit word drive port 3 swing when overridden.
// - bits 19:16 of transmit word drive port 3 de-emphasis when overridden.
// - bits 15:12 of transmit word drive port 2 swing when overridden.
// - bits 11:8 of transmit word drive port 2 de-emphasis when overridden.
// - bits 7:4 of transmit word drive port 1 swing when overridden.
// - bits 3:0 of transmit word drive port 1 de-emphasis when overridden.
// - equalizer bits 31:28 give port 4 init-mode value when overridden.
// - equalizer bits 27:24 give port 4 functional value when overridden.
// - equalizer bits 23:20 give port 3 init-mode value when overridden.
// - equalizer bits 19:16 give port 3 functional value when overridden.
// - equalizer bits 15:12 give port 2 init-mode value when overridden.
// - equalizer bits 11:8 give port 2 functional value when overridden.
// - equalizer bits 7:4 give port 1 init-mode value when overridden.
// - equalizer bits 3:0 give port 1 functional value when overridden.
// - on the two-port variant, port 3 and 4 fields have no effect.
// - override enables live in a read/write register at ECh, reset zero.
`timescale 1ns/1ps
module phy_tx_rx_tuning_override_regs
   import tuning_pkg::*;
#(
   parameter bit TWO_PORT = 1'b0
) (
   input  wire logic      clk,
   input  wire logic      srst,
   input  wire logic      pcie_reset_n,
   input  wire logic      global_reset_n,
   input  wire logic      por_n,
   input  wire cfg_req_s  cfg_req,
   output logic [31:0]    cfg_rdata,
   output logic           cfg_rvalid,
   output phy_port_s      phy_port [num_ports]
);

   logic [31:0] tx_tuning;
   logic [31:0] rx_eq;
   logic [31:0] override;
   logic [31:0] next_tx_tuning;
   logic [31:0] next_rx_eq;
   logic [31:0] next_override;
   logic [31:0] next_rdata;
   logic        next_rvalid;
   logic [2:0]  pin_level;
   logic        rst_all;
   logic [31:0] be_mask;
   logic [3:0]  swing_field  [num_ports];
   logic [3:0]  deemph_field [num_ports];
   logic [3:0]  init_field   [num_ports];
   logic [3:0]  func_field   [num_ports];

   ////////////////////////////////////////////////////////////////////////////
   // reset pins: synchronised and filtered before they reach any register
   pin_sync #(
      .W    (reset_pin_count),
      .INIT (reset_pin_idle)
   ) u_reset_pins (
      .clk   (clk),
      .srst  (srst),
      .pin   ({pcie_reset_n, global_reset_n, por_n}),
      .level (pin_level)
   );

   // any reset source clears the whole bank
   assign rst_all = srst || (pin_level != reset_pin_idle);

   ////////////////////////////////////////////////////////////////////////////
   // byte-enable mask of the current write
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         be_mask[b*8 +: 8] = {8{cfg_req.be[b]}};
      end
   end

   // register writes, merged by byte lane
   always_comb begin
      next_tx_tuning = tx_tuning;
      next_rx_eq     = rx_eq;
      next_override  = override;
      if (cfg_req.wr) begin
         case (cfg_req.addr)
            tx_tuning_offset: begin
               next_tx_tuning = (tx_tuning & ~be_mask) | (cfg_req.wdata & be_mask);
            end
            rx_eq_offset: begin
               next_rx_eq = (rx_eq & ~be_mask) | (cfg_req.wdata & be_mask);
            end
            override_offset: begin
               next_override = ((override & ~be_mask) | (cfg_req.wdata & be_mask))
                               & override_mask;
            end
            default: begin
               next_override = override;
            end
         endcase
      end
   end

   // register storage, cleared by every reset source
   always_ff @(posedge clk) begin
      if (rst_all) begin
         tx_tuning <= tx_tuning_reset;
         rx_eq     <= rx_eq_reset;
         override  <= override_reset;
      end else begin
         tx_tuning <= next_tx_tuning;
         rx_eq     <= next_rx_eq;
         override  <= next_override;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data: one cycle after the strobe, unmapped offsets read zero
   always_comb begin
      next_rvalid = cfg_req.rd;
      next_rdata  = 32'h0000_0000;
      if (cfg_req.rd) begin
         case (cfg_req.addr)
            tx_tuning_offset: next_rdata = tx_tuning;
            rx_eq_offset:     next_rdata = rx_eq;
            override_offset:  next_rdata = override;
            default:          next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // read answer registers
   always_ff @(posedge clk) begin
      if (rst_all) begin
         cfg_rdata  <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rdata  <= next_rdata;
         cfg_rvalid <= next_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-port field slicing and registered override selection
   for (genvar p = 0; p < num_ports; p++) begin : g_port
      // port p+1 owns byte p of each word: swing / init high, de-emph / func low
      assign swing_field[p]  = tx_tuning[p*port_stride + high_nibble_lo +: field_w];
      assign deemph_field[p] = tx_tuning[p*port_stride + low_nibble_lo  +: field_w];
      assign init_field[p]   = rx_eq[p*port_stride + high_nibble_lo +: field_w];
      assign func_field[p]   = rx_eq[p*port_stride + low_nibble_lo  +: field_w];

      port_override #(
         .PRESENT (!(TWO_PORT && (p >= two_port_count)))
      ) u_port (
         .clk       (clk),
         .rst       (rst_all),
         .field     ('{swing: swing_field[p], deemph: deemph_field[p],
                       eq_init: init_field[p], eq_func: func_field[p]}),
         .swing_ov  (override[p*ovr_stride + ovr_swing_bit]),
         .deemph_ov (override[p*ovr_stride + ovr_deemph_bit]),
         .eq_ov     (override[p*ovr_stride + ovr_eq_bit]),
         .q         (phy_port[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_all);

   sequence s_full_write(logic [7:0] off);
      cfg_req.wr && (cfg_req.addr == off) && (cfg_req.be == 4'hf);
   endsequence

   sequence s_read(logic [7:0] off);
      cfg_req.rd && (cfg_req.addr == off);
   endsequence

   property p_tx_write;
      s_full_write(tx_tuning_offset) |=> (tx_tuning == $past(cfg_req.wdata));
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("tx tuning write lost");

   property p_eq_write_read;
      s_full_write(rx_eq_offset) ##1 s_read(rx_eq_offset)
         |=> cfg_rvalid && (cfg_rdata == $past(cfg_req.wdata, 2));
   endproperty
   a_eq_write_read: assert property (p_eq_write_read) else $error("eq readback wrong");

   property p_reset_clear;
      @(posedge clk) disable iff (srst)
      rst_all |=> (tx_tuning == 32'h0000_0000) && (rx_eq == 32'h0000_0000)
                  && (override == 32'h0000_0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left value");

   property p_pin_reset;
      @(posedge clk) disable iff (srst)
      (!global_reset_n)[*5] |-> rst_all;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("global reset not seen");

   property p_p1_swing;
      override[ovr_swing_bit] |=> (phy_port[0].swing == $past(swing_field[0]));
   endproperty
   a_p1_swing: assert property (p_p1_swing) else $error("port 1 swing wrong");

   property p_p2_eq;
      override[ovr_stride + ovr_eq_bit]
         |=> (phy_port[1].eq_init == $past(init_field[1]))
             && (phy_port[1].eq_func == $past(func_field[1]));
   endproperty
   a_p2_eq: assert property (p_p2_eq) else $error("port 2 equalizer wrong");

   property p_p4_deemph;
      (!TWO_PORT && override[3*ovr_stride + ovr_deemph_bit])
         |=> (phy_port[3].deemph == $past(deemph_field[3]));
   endproperty
   a_p4_deemph: assert property (p_p4_deemph) else $error("port 4 de-emphasis wrong");

   property p_default;
      !override[2*ovr_stride + ovr_swing_bit]
         |=> (phy_port[2].swing == default_swing) && !phy_port[2].swing_ov;
   endproperty
   a_default: assert property (p_default) else $error("default swing not used");

   property p_two_port;
      TWO_PORT |-> !phy_port[3].eq_ov && (phy_port[3].eq_init == default_eq_init);
   endproperty
   a_two_port: assert property (p_two_port) else $error("absent port took field");

   property p_ovr_read;
      s_read(override_offset) |=> cfg_rvalid && (cfg_rdata == $past(override))
                                  && ((cfg_rdata & ~override_mask) == 32'h0000_0000);
   endproperty
   a_ovr_read: assert property (p_ovr_read) else $error("override readback wrong");

endmodule

// *** phy_model.sv ***
// phy_model: behavioural stand-in for the usb3 phy analog front end.
// assumes the phy_port bundle from the tuning bank, one entry per port.
`timescale 1ns/1ps
module phy_model
   import tuning_pkg::*;
(
   input  wire phy_port_s phy_in  [num_ports],
   output tuning_s        applied [num_ports]
);

   ////////////////////////////////////////////////////////////////////////////
   // settings the analog side really uses: built-in default unless overridden
   always_comb begin
      for (int i = 0; i < num_ports; i++) begin
         applied[i].swing   = phy_in[i].swing_ov  ? phy_in[i].swing   : default_swing;
         applied[i].deemph  = phy_in[i].deemph_ov ? phy_in[i].deemph  : default_deemph;
         applied[i].eq_init = phy_in[i].eq_ov     ? phy_in[i].eq_init : default_eq_init;
         applied[i].eq_func = phy_in[i].eq_ov     ? phy_in[i].eq_func : default_eq_func;
      end
   end

endmodule

// *** phy_tx_rx_tuning_override_regs_tb_top.sv ***
// testbench for the phy tuning register bank: config access, overrides,
// reset pins and the two-port variant.
// assumes the bank's registered config port and one-cycle phy latency.
`timescale 1ns/1ps
module phy_tx_rx_tuning_override_regs_tb_top
   import tuning_pkg::*;
   ;
   logic        clk;
   logic        srst;
   logic        pcie_reset_n;
   logic        global_reset_n;
   logic        por_n;
   cfg_req_s    cfg_req;
   logic [31:0] cfg_rdata;
   logic        cfg_rvalid;
   phy_port_s   phy_port [num_ports];
   phy_port_s   two_port [num_ports];
   tuning_s     applied  [num_ports];
   int          errors;
   int          comparisons;
   logic [31:0] tx_val;
   logic [31:0] eq_val;
   logic [31:0] ov_val;

   // short alias for the transmit tuning offset used throughout the scenarios
   localparam logic [7:0] tx_offset = tx_tuning_offset;

   ////////////////////////////////////////////////////////////////////////////
   // clock, design instances and the phy model
   always #20 clk = ~clk;

   phy_tx_rx_tuning_override_regs #(.TWO_PORT(1'b0)) dut_u (
      .clk(clk), .srst(srst), .pcie_reset_n(pcie_reset_n),
      .global_reset_n(global_reset_n), .por_n(por_n), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .phy_port(phy_port));

   phy_tx_rx_tuning_override_regs #(.TWO_PORT(1'b1)) dut_two_u (
      .clk(clk), .srst(srst), .pcie_reset_n(pcie_reset_n),
      .global_reset_n(global_reset_n), .por_n(por_n), .cfg_req(cfg_req),
      .cfg_rdata(), .cfg_rvalid(), .phy_port(two_port));

   phy_model phy_u (.phy_in(phy_port), .applied(applied));

   ////////////////////////////////////////////////////////////////////////////
   // verdict, comparison and expectation helpers
   task automatic test_done();
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         if (be[b]) old[8*b +: 8] = d[8*b +: 8];
      end
      return old;
   endfunction

   // expected phy bundle of port i; two selects the two-port variant
   function automatic phy_port_s exp_port(input int i, input logic two);
      phy_port_s e;
      e = '0;
      if (!(two && i >= two_port_count)) begin
         e.swing_ov  = ov_val[ovr_stride*i + ovr_swing_bit];
         e.deemph_ov = ov_val[ovr_stride*i + ovr_deemph_bit];
         e.eq_ov     = ov_val[ovr_stride*i + ovr_eq_bit];
         e.swing     = e.swing_ov  ? tx_val[8*i+4 +: 4] : default_swing;
         e.deemph    = e.deemph_ov ? tx_val[8*i   +: 4] : default_deemph;
         e.eq_init   = e.eq_ov     ? eq_val[8*i+4 +: 4] : default_eq_init;
         e.eq_func   = e.eq_ov     ? eq_val[8*i   +: 4] : default_eq_func;
      end
      return e;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // config bus tasks: strobe for one cycle, track the expected contents
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
      @(negedge clk);
      cfg_req = '0;
      if (a == tx_offset) tx_val = merge(tx_val, d, be);
      if (a == rx_eq_offset) eq_val = merge(eq_val, d, be);
      if (a == override_offset) ov_val = merge(ov_val, d, be) & override_mask;
   endtask

   task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
      int n;
      @(negedge clk);
      cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0000_0000};
      for (n = 0; n < 4 && cfg_rvalid !== 1'b1; n++) begin
         @(negedge clk);
         cfg_req = '0;
      end
      if (n == 4) begin
         errors++;
         test_done();
      end
      chk(cfg_rdata, exp);
      @(negedge clk);
      chk(32'(cfg_rvalid), 32'h0000_0000);
      chk(cfg_rdata, 32'h0000_0000);
   endtask

   // phy bundles follow one cycle after the register update
   task automatic chk_ports();
      phy_port_s e;
      @(negedge clk);
      for (int i = 0; i < num_ports; i++) begin
         e = exp_port(i, 1'b0);
         chk(32'(phy_port[i]), 32'(e));
         chk(32'(applied[i]), 32'(e[18:3]));
         chk(32'(two_port[i]), 32'(exp_port(i, 1'b1)));
      end
   endtask

   task automatic rd_all();
      cfg_rd(tx_offset, tx_val);
      cfg_rd(rx_eq_offset, eq_val);
      cfg_rd(override_offset, ov_val);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset_and_rw();
      rd_all();
      cfg_rd(8'hf0, 32'h0000_0000);
      cfg_wr(tx_offset, 4'hf, 32'h1234_5678);
      cfg_wr(rx_eq_offset, 4'hf, 32'h9abc_def1);
      cfg_wr(8'hf0, 4'hf, 32'hffff_ffff);
      chk_ports();
      rd_all();
   endtask

   // every override bit alone, then all of them with reserved bits
   task automatic t_override_walk();
      for (int p = 0; p < num_ports; p++) begin
         for (int b = 0; b < 3; b++) begin
            cfg_wr(override_offset, 4'hf, 32'h0000_0001 << (ovr_stride*p + b));
            chk_ports();
         end
      end
      cfg_wr(override_offset, 4'hf, 32'hffff_ffff);
      cfg_wr(tx_offset, 4'h5, 32'hfedc_ba98);
      cfg_wr(rx_eq_offset, 4'ha, 32'h0f1e_2d3c);
      chk_ports();
      rd_all();
   endtask

   // write, then write and read in one cycle in the next cycle; the read returns the first write
   task automatic t_back_to_back();
      @(negedge clk);
      cfg_req = '{wr: 1'b1, rd: 1'b0, addr: rx_eq_offset, be: 4'hf, wdata: 32'h2468_ace0};
      @(negedge clk);
      cfg_req = '{wr: 1'b1, rd: 1'b1, addr: rx_eq_offset, be: 4'hf, wdata: 32'h1357_9bdf};
      @(negedge clk);
      cfg_req = '0;
      chk(32'(cfg_rvalid), 32'h0000_0001);
      chk(cfg_rdata, 32'h2468_ace0);
      eq_val = 32'h1357_9bdf;
      cfg_rd(rx_eq_offset, eq_val);
   endtask

   // each reset pin alone, then srst in mid-run, clears the whole bank
   task automatic t_resets();
      for (int w = 0; w < 4; w++) begin
         cfg_wr(tx_offset, 4'hf, 32'h5a5a_a5a5);
         cfg_wr(rx_eq_offset, 4'hf, 32'hc3c3_3c3c);
         cfg_wr(override_offset, 4'hf, 32'h0000_7777);
         @(negedge clk);
         pcie_reset_n = (w != 0);
         global_reset_n = (w != 1);
         por_n = (w != 2);
         srst = (w == 3);
         repeat (6) @(negedge clk);
         {pcie_reset_n, global_reset_n, por_n} = reset_pin_idle;
         srst = 1'b0;
         repeat (6) @(negedge clk);
         tx_val = tx_tuning_reset;
         eq_val = rx_eq_reset;
         ov_val = override_reset;
         rd_all();
         chk_ports();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      {pcie_reset_n, global_reset_n, por_n} = reset_pin_idle;
      cfg_req = '0;
      errors = 0;
      comparisons = 0;
      tx_val = tx_tuning_reset;
      eq_val = rx_eq_reset;
      ov_val = override_reset;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      t_reset_and_rw();
      t_override_walk();
      t_back_to_back();
      t_resets();
      test_done();
   end

endmodule
